/* src/nvm_ctrl.sv */
// EEPROM save/load control: registers, buffer segment walk and EEPROM port
//
// Contract
// - 0xB00 bit 0 reads transfer busy
// - Status pin shows busy when selected
// - 0xB01 bit 0 reads load data error
// - Reload bit with pin low soft-resets from EEPROM
// - Write enable bit, default off, gates saving
// - Save bit starts save, clears at end
// - Command bit7 low: length, two address bytes
// - Update opcode pulses update; end opcode terminates
`include "nvm_map.svh"
`default_nettype none

module nvm_ctrl #(
	parameter int NVM_AW = 10
) (
	// Clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_RST,
	// Register access from the serial port
	input  wire logic [11:0]       I_REG_ADDR,
	input  wire logic              I_REG_WR,
	input  wire logic              I_REG_RD,
	input  wire logic [7:0]        I_REG_WDATA,
	output logic [7:0]             O_REG_RDATA,
	// Status pin and its select bit
	input  wire logic              I_STATUS_SEL,
	output logic                   O_STATUS_PIN,
	// EEPROM select pin, low enables reload
	input  wire logic              I_NVM_PIN_N,
	// Buffer register bank
	output logic [11:0]            O_BUF_RADDR,
	input  wire logic [7:0]        I_BUF_RDATA,
	output logic                   O_BUF_WE,
	output logic [11:0]            O_BUF_WADDR,
	output logic [7:0]             O_BUF_WDATA,
	// Device events
	output logic                   O_IO_UPDATE,
	output logic                   O_SOFT_RESET,
	// EEPROM array port
	output logic                   O_NVM_WE,
	output logic                   O_NVM_RE,
	output logic [NVM_AW-1:0]      O_NVM_ADDR,
	output logic [7:0]             O_NVM_WDATA,
	input  wire logic              I_NVM_DONE,
	input  wire logic [7:0]        I_NVM_RDATA
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	nvm_pkg::walk_e    st_q, st_d;
	nvm_pkg::reg_addr_t ptr_q, adr_q;
	nvm_pkg::byte_t    sum_q, rdata_q;
	logic [6:0]        len_q;
	logic [NVM_AW-1:0] nptr_q;
	logic              save_q, wr_en_q, err_q, busy_q, pin_s1_q, pin_s2_q;
	logic              upd_q, soft_q, nwe_q, nre_q, bwe_q;
	logic [7:0]        nwdata_q, bwdata_q;
	logic [11:0]       bwaddr_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic       is_xfer, is_update, is_end;
	logic [6:0] len_m1;

	nvm_cmd_decode u_dec (
		.i_cmd       (I_BUF_RDATA),
		.o_is_xfer   (is_xfer),
		.o_len_m1    (len_m1),
		.o_is_update (is_update),
		.o_is_end    (is_end)
	);

	wire wr_reload = I_REG_WR && (I_REG_ADDR == `NVM_OFS_RELOAD);
	wire wr_save   = I_REG_WR && (I_REG_ADDR == `NVM_OFS_SAVE);
	wire idle      = (st_q == nvm_pkg::ST_IDLE);
	// Saving needs write enable; a protected request is dropped whole
	wire start_save = wr_save && I_REG_WDATA[`NVM_BIT_SAVE] && wr_en_q && idle;
	// Reload only honoured with the select pin low
	wire start_load = wr_reload && I_REG_WDATA[`NVM_BIT_RELOAD] && !pin_s2_q && idle;
	wire in_cmd     = (st_q == nvm_pkg::ST_CMD);
	wire seg_last   = (ptr_q == `NVM_SEG_LAST);
	wire cmd_stop   = in_cmd && (is_end || (!is_xfer && seg_last));
	wire at_hdr     = in_cmd || (st_q == nvm_pkg::ST_ADR_HI) || (st_q == nvm_pkg::ST_ADR_LO);
	wire done_data  = (st_q == nvm_pkg::ST_WAIT) && I_NVM_DONE;
	wire done_sum   = (st_q == nvm_pkg::ST_SUM_WAIT) && I_NVM_DONE;
	wire [7:0] load_byte = I_NVM_RDATA;

	assign O_BUF_RADDR = at_hdr ? ptr_q : adr_q;
	assign O_STATUS_PIN = I_STATUS_SEL && busy_q;

	// ----------------------------------------------------------------
	// Segment walk
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			nvm_pkg::ST_IDLE:     if (start_save || start_load) st_d = nvm_pkg::ST_CMD;
			nvm_pkg::ST_CMD: begin
				if (cmd_stop)     st_d = nvm_pkg::ST_SUM;
				else if (is_xfer) st_d = nvm_pkg::ST_ADR_HI;
			end
			nvm_pkg::ST_ADR_HI:   st_d = nvm_pkg::ST_ADR_LO;
			nvm_pkg::ST_ADR_LO:   st_d = nvm_pkg::ST_DATA;
			nvm_pkg::ST_DATA:     st_d = nvm_pkg::ST_WAIT;
			nvm_pkg::ST_WAIT: begin
				if (I_NVM_DONE)   st_d = (len_q == 7'h00) ? nvm_pkg::ST_CMD : nvm_pkg::ST_DATA;
			end
			nvm_pkg::ST_SUM:      st_d = nvm_pkg::ST_SUM_WAIT;
			nvm_pkg::ST_SUM_WAIT: if (I_NVM_DONE) st_d = nvm_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_q <= nvm_pkg::ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Pointers, length and running checksum
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ptr_q  <= `NVM_SEG_FIRST;
			adr_q  <= 12'h000;
			len_q  <= 7'h00;
			nptr_q <= '0;
			sum_q  <= 8'h00;
		end else begin
			if (idle) begin
				ptr_q  <= `NVM_SEG_FIRST;
				nptr_q <= '0;
				sum_q  <= 8'h00;
			end
			if (at_hdr && !cmd_stop)
				ptr_q <= ptr_q + 12'h001;
			if (in_cmd && is_xfer)
				len_q <= len_m1;
			if (st_q == nvm_pkg::ST_ADR_HI)
				adr_q <= {I_BUF_RDATA[3:0], adr_q[7:0]};
			if (st_q == nvm_pkg::ST_ADR_LO)
				adr_q <= {adr_q[11:8], I_BUF_RDATA};
			if (st_q == nvm_pkg::ST_DATA && save_q)
				sum_q <= sum_q ^ I_BUF_RDATA;
			if (done_data) begin
				nptr_q <= nptr_q + NVM_AW'(1);
				adr_q  <= adr_q + 12'h001;
				len_q  <= len_q - 7'h01;
				if (!save_q)
					sum_q <= sum_q ^ load_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Port strobes
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			nwe_q    <= 1'b0;
			nre_q    <= 1'b0;
			nwdata_q <= 8'h00;
			bwe_q    <= 1'b0;
			bwdata_q <= 8'h00;
			bwaddr_q <= 12'h000;
			upd_q    <= 1'b0;
			soft_q   <= 1'b0;
		end else begin
			nwe_q  <= save_q && wr_en_q &&
			          (st_q == nvm_pkg::ST_DATA || st_q == nvm_pkg::ST_SUM);
			nre_q  <= !save_q && (st_q == nvm_pkg::ST_DATA || st_q == nvm_pkg::ST_SUM);
			if (st_q == nvm_pkg::ST_DATA)
				nwdata_q <= I_BUF_RDATA;
			if (st_q == nvm_pkg::ST_SUM)
				nwdata_q <= sum_q;
			bwe_q    <= done_data && !save_q;
			bwdata_q <= load_byte;
			bwaddr_q <= adr_q;
			upd_q    <= in_cmd && is_update;
			soft_q   <= start_load;
		end
	end

	assign O_NVM_WE    = nwe_q;
	assign O_NVM_RE    = nre_q;
	assign O_NVM_ADDR  = nptr_q;
	assign O_NVM_WDATA = nwdata_q;
	assign O_BUF_WE    = bwe_q;
	assign O_BUF_WADDR = bwaddr_q;
	assign O_BUF_WDATA = bwdata_q;
	assign O_IO_UPDATE = upd_q;
	assign O_SOFT_RESET = soft_q;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Pin is asynchronous to the serial clock
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= I_NVM_PIN_N;
			pin_s2_q <= pin_s1_q;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			wr_en_q <= `NVM_WR_EN_RST;
			save_q  <= 1'b0;
			err_q   <= 1'b0;
			busy_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			if (wr_reload && idle)   // Frozen mid-walk, else a save would hang
				wr_en_q <= I_REG_WDATA[`NVM_BIT_WR_EN];
			if (start_save)
				save_q <= 1'b1;
			else if (done_sum)
				save_q <= 1'b0;
			if (start_load)
				err_q <= 1'b0;
			else if (done_sum && !save_q)
				err_q <= (load_byte != sum_q);
			busy_q <= (st_d != nvm_pkg::ST_IDLE);
			if (I_REG_RD) begin
				unique case (I_REG_ADDR)
					`NVM_OFS_STATUS: rdata_q <= {7'h00, busy_q};
					`NVM_OFS_ERROR:  rdata_q <= {7'h00, err_q};
					`NVM_OFS_RELOAD: rdata_q <= {7'h00, wr_en_q};
					`NVM_OFS_SAVE:   rdata_q <= {7'h00, save_q};
					default:         rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign O_REG_RDATA = rdata_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_busy_read;
		@(posedge I_CLK) disable iff (I_RST)
		I_REG_RD && I_REG_ADDR == `NVM_OFS_STATUS |=> O_REG_RDATA == {7'h00, $past(busy_q)};
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy read wrong");

	property p_status_pin;
		@(posedge I_CLK) disable iff (I_RST)
		O_STATUS_PIN |-> I_STATUS_SEL && !idle;
	endproperty
	a_status_pin: assert property (p_status_pin) else $error("status pin wrong");

	property p_err_read;
		@(posedge I_CLK) disable iff (I_RST)
		I_REG_RD && I_REG_ADDR == `NVM_OFS_ERROR |=> O_REG_RDATA == {7'h00, $past(err_q)};
	endproperty
	a_err_read: assert property (p_err_read) else $error("error read wrong");

	property p_soft;
		@(posedge I_CLK) disable iff (I_RST)
		wr_reload && I_REG_WDATA[1] && !pin_s2_q && idle |=> O_SOFT_RESET ##1 busy_q;
	endproperty
	a_soft: assert property (p_soft) else $error("reload not started");

	property p_protect;
		@(posedge I_CLK) disable iff (I_RST)
		wr_save && !wr_en_q && idle |=> idle && !save_q;
	endproperty
	a_protect: assert property (p_protect) else $error("protected save began");

	property p_no_write;
		@(posedge I_CLK) disable iff (I_RST)
		O_NVM_WE |-> wr_en_q && save_q;
	endproperty
	a_no_write: assert property (p_no_write) else $error("EEPROM written");

	property p_save_clear;
		@(posedge I_CLK) disable iff (I_RST)
		(start_save |=> save_q && busy_q) and (!busy_q |-> !save_q);
	endproperty
	a_save_clear: assert property (p_save_clear) else $error("save bit dropped");

	property p_xfer;
		@(posedge I_CLK) disable iff (I_RST)
		in_cmd && !I_BUF_RDATA[7] |=> st_q == nvm_pkg::ST_ADR_HI ##2 st_q == nvm_pkg::ST_DATA;
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer decode wrong");

	property p_opcodes;
		@(posedge I_CLK) disable iff (I_RST)
		in_cmd && I_BUF_RDATA == `NVM_OP_END |=> st_q == nvm_pkg::ST_SUM && !O_IO_UPDATE;
	endproperty
	a_opcodes: assert property (p_opcodes) else $error("end code wrong");

endmodule // nvm_ctrl

`default_nettype wire

/* src/nvm_map.svh */
// Register offsets, field positions, reset values and codes of the EEPROM save/load control
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define NVM_OFS_STATUS      12'hb00
`define NVM_OFS_ERROR       12'hb01
`define NVM_OFS_RELOAD      12'hb02
`define NVM_OFS_SAVE        12'hb03

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define NVM_BIT_BUSY        0
`define NVM_BIT_ERROR       0
`define NVM_BIT_WR_EN       0
`define NVM_BIT_RELOAD      1
`define NVM_BIT_SAVE        0
`define NVM_WR_EN_RST       1'b0

// ----------------------------------------------------------------
// Buffer segment and command bytes
// ----------------------------------------------------------------
`define NVM_SEG_FIRST       12'ha00
`define NVM_SEG_LAST        12'haff
`define NVM_CMD_OPCODE_BIT  7
`define NVM_OP_UPDATE       8'h80
`define NVM_OP_END          8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Least gap between transfers, kept by the host; ns and 100 MHz cycles
`define NVM_GAP_NS          10000
`define NVM_CLK_NS          10
`define NVM_GAP_CYC         ((`NVM_GAP_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)

`endif

/* src/nvm_pkg.sv */
// Types shared by the EEPROM save/load control
`default_nettype none

package nvm_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CMD,
		ST_ADR_HI,
		ST_ADR_LO,
		ST_DATA,
		ST_WAIT,
		ST_SUM,
		ST_SUM_WAIT
	} walk_e;

	typedef logic [7:0]  byte_t;
	typedef logic [11:0] reg_addr_t;

endpackage : nvm_pkg

`default_nettype wire

/* src/nvm_cmd_decode.sv */
// Decoder of one buffer segment command byte
`include "nvm_map.svh"
`default_nettype none

module nvm_cmd_decode (
	// Command byte
	input  wire logic [7:0] i_cmd,
	// Decoded kind
	output logic            o_is_xfer,
	output logic [6:0]      o_len_m1,
	output logic            o_is_update,
	output logic            o_is_end
);

	assign o_is_xfer   = ~i_cmd[`NVM_CMD_OPCODE_BIT];
	assign o_len_m1    = i_cmd[6:0];
	assign o_is_update = (i_cmd == `NVM_OP_UPDATE);
	assign o_is_end    = (i_cmd == `NVM_OP_END);

endmodule // nvm_cmd_decode

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the EEPROM save/load control
`include "nvm_map.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic           clk = 1'b0;
	logic           rst = 1'b1;
	logic [11:0]    addr = '0;
	logic           wr = 1'b0;
	logic           rd = 1'b0;
	logic [7:0]     wdata = '0;
	logic           sel = 1'b1;
	logic           pin_n = 1'b1;
	logic           ndone = 1'b0;
	logic [7:0]     nrdata = '0;
	logic [7:0]     rdata;
	logic           pin;
	logic [11:0]    braddr;
	logic [11:0]    bwaddr;
	logic [7:0]     bwdata;
	logic [7:0]     nwdata;
	logic [9:0]     naddr;
	logic [9:0]     a;
	logic           bwe;
	logic           upd;
	logic           srst;
	logic           nwe;
	logic           nre;
	nvm_pkg::byte_t buf_mem [4096];
	nvm_pkg::byte_t nvm_mem [1024];
	int             num_errors = 0;
	int             cmp_count = 0;
	int             n_upd = 0;
	int             n_srst = 0;
	int             exp_q [$];

	nvm_ctrl #(.NVM_AW(10)) i_dut (
		.I_CLK(clk), .I_RST(rst),
		.I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
		.O_REG_RDATA(rdata),
		.I_STATUS_SEL(sel), .O_STATUS_PIN(pin), .I_NVM_PIN_N(pin_n),
		.O_BUF_RADDR(braddr), .I_BUF_RDATA(buf_mem[braddr]),
		.O_BUF_WE(bwe), .O_BUF_WADDR(bwaddr), .O_BUF_WDATA(bwdata),
		.O_IO_UPDATE(upd), .O_SOFT_RESET(srst),
		.O_NVM_WE(nwe), .O_NVM_RE(nre), .O_NVM_ADDR(naddr), .O_NVM_WDATA(nwdata),
		.I_NVM_DONE(ndone), .I_NVM_RDATA(nrdata)
	);

	always #5 clk = ~clk;

	// ----------------------------------------------------------------
	// Buffer bank and EEPROM array
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (bwe)
			buf_mem[bwaddr] <= bwdata;
		if (nwe)
			nvm_mem[naddr] <= nwdata;
		n_upd <= n_upd + int'(upd);
		n_srst <= n_srst + int'(srst);
	end

	// Slow array; read data is scrambled outside the done cycle
	initial forever begin
		@(negedge clk);
		if (nwe || nre) begin
			a = naddr;
			repeat (20) @(negedge clk);
			nrdata = nvm_mem[a];
			ndone = 1'b1;
			@(negedge clk);
			ndone = 1'b0;
			nrdata = ~nrdata;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [11:0] ad, input logic [7:0] v);
		@(negedge clk);
		addr = ad;
		wdata = v;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rreg(input logic [11:0] ad, input logic [7:0] exp);
		@(negedge clk);
		addr = ad;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, exp);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (pin !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n < 2000), 8'h01);
		repeat (`NVM_GAP_CYC) @(negedge clk);
	endtask

	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h06d6));
		foreach (buf_mem[i]) buf_mem[i] = 8'h00;
		foreach (nvm_mem[i]) nvm_mem[i] = 8'h00;
		buf_mem[12'ha00] = 8'h01;
		buf_mem[12'ha02] = 8'h10;
		buf_mem[12'ha03] = `NVM_OP_UPDATE;
		buf_mem[12'ha04] = `NVM_OP_END;
		buf_mem[16] = 8'($urandom);
		buf_mem[17] = 8'($urandom);
		exp_q = {buf_mem[16], buf_mem[17], buf_mem[16] ^ buf_mem[17]};
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rreg(`NVM_OFS_STATUS, 8'h00);
		rreg(`NVM_OFS_ERROR, 8'h00);
		rreg(`NVM_OFS_RELOAD, 8'h00);
		rreg(12'hb04, 8'h00);
		// Save refused while protected
		wreg(`NVM_OFS_SAVE, 8'h01);
		rreg(`NVM_OFS_SAVE, 8'h00);
		chk(8'(pin), 8'h00);
		repeat (100) @(negedge clk);
		for (int i = 0; i < 3; i++) chk(nvm_mem[i], 8'h00);
		// Save with writes enabled; pin hidden until selected
		wreg(`NVM_OFS_RELOAD, 8'h01);
		rreg(`NVM_OFS_RELOAD, 8'h01);
		sel = 1'b0;
		wreg(`NVM_OFS_SAVE, 8'h01);
		rreg(`NVM_OFS_STATUS, 8'h01);
		chk(8'(pin), 8'h00);
		rreg(`NVM_OFS_SAVE, 8'h01);
		sel = 1'b1;
		@(negedge clk);
		chk(8'(pin), 8'h01);
		wait_idle();
		rreg(`NVM_OFS_STATUS, 8'h00);
		rreg(`NVM_OFS_SAVE, 8'h00);
		foreach (exp_q[i]) chk(nvm_mem[i], 8'(exp_q[i]));
		chk(8'(n_upd), 8'h01);
		// Reload refused while the select pin is high
		wreg(`NVM_OFS_RELOAD, 8'h03);
		repeat (5) @(negedge clk);
		chk(8'(n_srst), 8'h00);
		chk(8'(pin), 8'h00);
		// Reload from the array into a corrupted buffer
		pin_n = 1'b0;
		buf_mem[16] = ~buf_mem[16];
		buf_mem[17] = ~buf_mem[17];
		repeat (3) @(negedge clk);
		wreg(`NVM_OFS_RELOAD, 8'h03);
		rreg(`NVM_OFS_RELOAD, 8'h01);
		wait_idle();
		chk(8'(n_srst), 8'h01);
		chk(8'(n_upd), 8'h02);
		chk(buf_mem[16], 8'(exp_q[0]));
		chk(buf_mem[17], 8'(exp_q[1]));
		rreg(`NVM_OFS_ERROR, 8'h00);
		// Reload with a damaged checksum byte
		nvm_mem[2] = ~nvm_mem[2];
		wreg(`NVM_OFS_RELOAD, 8'h03);
		wait_idle();
		rreg(`NVM_OFS_ERROR, 8'h01);
		close_out();
	end
endmodule // tb_top

`default_nettype wire
